//--- converter_mode_and_tune_control.sv
// Purpose: mode select, control pins, channel sleep, tuning trigger, tune array
// Assumes: pins asynchronous to clk; serial port much slower than clk
// Notes: data pin tri-state shown as output enables
`timescale 1ns/10ps
`include "converter_ctrl_cfg.svh"
module converter_mode_and_tune_control (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control pins
    input wire logic modeSelectPin,
    input wire logic singleBusSelect,
    input wire logic outputPhasePin,
    input wire logic tunePin,
    input wire logic iChannelSleepPin,
    input wire logic qChannelSleepPin,
    input wire logic fullScaleSelect,
    // serial register port
    input wire logic scsN,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdoOut,
    output logic sdoOe,
    // converter controls
    output logic registerControlMode,
    output logic singleBusMode,
    output logic outputPhase90,
    output logic iSleep,
    output logic qSleep,
    output logic iDataOe,
    output logic qDataOe,
    output logic fullScaleHighI,
    output logic fullScaleHighQ,
    output logic tuneRunning,
    output logic dataForceLow
);
    import converter_ctrl_pkg::*;

    function automatic word_t defaultOf(input regAddr_t a);
        if (a == `REG_MAIN) return `MAIN_DEFAULT;
        else if (a == `REG_TUNE_ADJ) return `TUNE_ADJ_DEFAULT;
        else return `OTHER_DEFAULT;
    endfunction : defaultOf

    function automatic logic isTuneVal(input regAddr_t a);
        return a == `REG_TUNE_VAL;
    endfunction : isTuneVal

    // pin synchronisers
    logic [6:0] pinMeta;
    logic [6:0] pinSync;
    logic modeS, busS, phaseS, tuneS, iPinS, qPinS, fsS, regMode;
    assign {modeS, busS, phaseS, tuneS, iPinS, qPinS, fsS} = pinSync;
    assign regMode = ~modeS;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pinMeta <= `PIN_SYNC_IDLE;
            pinSync <= `PIN_SYNC_IDLE;
        end else begin
            pinMeta <= {modeSelectPin, singleBusSelect, outputPhasePin, tunePin,
                        iChannelSleepPin, qChannelSleepPin, fullScaleSelect};
            pinSync <= pinMeta;
        end
    end

    // serial port
    logic rdReq, wrStb;
    regAddr_t rdAddr, wrAddr;
    word_t rdData, wrData;

    converter_serial_port u_port (
        .clk(clk),
        .rstn(rstn),
        .portEnable(regMode),
        .scsN(scsN),
        .sclk(sclk),
        .sdi(sdi),
        .sdoOut(sdoOut),
        .sdoOe(sdoOe),
        .rdReq(rdReq),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .wrStb(wrStb),
        .wrAddr(wrAddr),
        .wrData(wrData)
    );

    // register bank and tune array
    word_t regBank [0:15];
    word_t next_regBank [0:15];
    word_t tuneArray [0:182];
    word_t next_rdData;
    arrayIdx_t ptr, next_ptr;
    logic firstPending, next_firstPending;
    logic accessPrev, tuneBitPrev;
    logic arrWe;
    logic access, accessRise, tuneBitRise;

    assign access = regMode & regBank[`REG_TUNE_ADJ][`BIT_ARRAY];
    assign accessRise = access & ~accessPrev;
    assign tuneBitRise = regMode & regBank[`REG_MAIN][`BIT_TUNE] & ~tuneBitPrev;

    always_comb begin
        next_regBank = regBank;
        if (!regMode) begin
            for (int i = 0; i < 16; i++) begin
                next_regBank[i] = defaultOf(4'(i));
            end
        end else if (wrStb && !isTuneVal(wrAddr)) begin
            next_regBank[wrAddr] = wrData;
        end
    end

    always_comb begin
        next_ptr = ptr;
        next_firstPending = firstPending;
        next_rdData = rdData;
        arrWe = 1'b0;
        if (accessRise) begin
            next_ptr = 8'h00;
            next_firstPending = 1'b1;
        end
        if (rdReq) begin
            if (!isTuneVal(rdAddr)) begin
                next_rdData = regBank[rdAddr];
            end else if (!access || ptr >= `TUNE_ARRAY_LEN) begin
                next_rdData = `ZERO_WORD;
            end else if (firstPending) begin
                next_rdData = `ZERO_WORD;
                next_firstPending = 1'b0;
            end else begin
                next_rdData = tuneArray[ptr];
                next_ptr = ptr + 8'h01;
            end
        end
        // extra writes past the last slot are ignored
        if (wrStb && isTuneVal(wrAddr) && access && ptr < `TUNE_ARRAY_LEN) begin
            arrWe = 1'b1;
            next_ptr = ptr + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (arrWe) begin
            tuneArray[ptr] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 16; i++) begin
                regBank[i] <= defaultOf(4'(i));
            end
            ptr <= 8'h00;
            firstPending <= 1'b0;
            rdData <= 16'h0000;
            accessPrev <= 1'b0;
            tuneBitPrev <= 1'b0;
        end else begin
            regBank <= next_regBank;
            ptr <= next_ptr;
            firstPending <= next_firstPending;
            rdData <= next_rdData;
            accessPrev <= access;
            tuneBitPrev <= regMode & regBank[`REG_MAIN][`BIT_TUNE];
        end
    end

    // tuning trigger and run
    tuneState_t tuneState, next_tuneState;
    logic [15:0] tuneCnt, next_tuneCnt;

    always_comb begin
        next_tuneState = tuneState;
        next_tuneCnt = tuneCnt;
        case (tuneState)
            TUNE_SEEK_LOW: begin
                if (tuneS) begin
                    next_tuneCnt = 16'h0000;
                end else if (tuneCnt >= `TUNE_LOW_CYC - 16'h0001) begin
                    next_tuneState = TUNE_SEEK_HIGH;
                    next_tuneCnt = 16'h0000;
                end else begin
                    next_tuneCnt = tuneCnt + 16'h0001;
                end
            end
            TUNE_SEEK_HIGH: begin
                if (!tuneS) begin
                    next_tuneCnt = 16'h0000;
                end else if (tuneCnt >= `TUNE_HIGH_CYC - 16'h0001) begin
                    next_tuneState = TUNE_RUN;
                    next_tuneCnt = 16'h0000;
                end else begin
                    next_tuneCnt = tuneCnt + 16'h0001;
                end
            end
            TUNE_RUN: begin
                if (tuneCnt >= `TUNE_RUN_CYC - 16'h0001) begin
                    next_tuneState = TUNE_SEEK_LOW;
                    next_tuneCnt = 16'h0000;
                end else begin
                    next_tuneCnt = tuneCnt + 16'h0001;
                end
            end
            default: begin
                next_tuneState = TUNE_SEEK_LOW;
                next_tuneCnt = 16'h0000;
            end
        endcase
        if (tuneBitRise && tuneState != TUNE_RUN) begin
            next_tuneState = TUNE_RUN;
            next_tuneCnt = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tuneState <= TUNE_SEEK_LOW;
            tuneCnt <= 16'h0000;
        end else begin
            tuneState <= next_tuneState;
            tuneCnt <= next_tuneCnt;
        end
    end

    // registered converter controls
    logic next_iSleep, next_qSleep, next_phase, next_fsI, next_fsQ, next_run;
    word_t mainReg;
    assign mainReg = regBank[`REG_MAIN];

    always_comb begin
        next_iSleep = iPinS | (regMode & mainReg[`BIT_SLEEP_I]);
        next_qSleep = qPinS | (regMode & mainReg[`BIT_SLEEP_Q]);
        next_phase = regMode ? mainReg[`BIT_PHASE] : phaseS;
        next_fsI = regMode ? regBank[`REG_RANGE_I][`BIT_RANGE] : fsS;
        next_fsQ = regMode ? regBank[`REG_RANGE_Q][`BIT_RANGE] : fsS;
        next_run = next_tuneState == TUNE_RUN;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            registerControlMode <= 1'b0;
            singleBusMode <= 1'b0;
            outputPhase90 <= 1'b0;
            iSleep <= 1'b0;
            qSleep <= 1'b0;
            iDataOe <= 1'b0;
            qDataOe <= 1'b0;
            fullScaleHighI <= 1'b0;
            fullScaleHighQ <= 1'b0;
            tuneRunning <= 1'b0;
            dataForceLow <= 1'b0;
        end else begin
            registerControlMode <= regMode;
            singleBusMode <= busS;
            outputPhase90 <= next_phase;
            iSleep <= next_iSleep;
            qSleep <= next_qSleep;
            iDataOe <= ~next_iSleep;
            qDataOe <= ~next_qSleep;
            fullScaleHighI <= next_fsI;
            fullScaleHighQ <= next_fsQ;
            tuneRunning <= next_run;
            dataForceLow <= next_run;
        end
    end

    // checks
    property p_sleepPin;
        @(posedge clk) disable iff (!rstn) iPinS |=> iSleep && !iDataOe;
    endproperty
    a_sleepPin: assert property (p_sleepPin) else $error("i pin sleep lost");

    property p_sleepOe;
        @(posedge clk) disable iff (!rstn) (qSleep |-> !qDataOe) and (iSleep |-> !iDataOe);
    endproperty
    a_sleepOe: assert property (p_sleepOe) else $error("sleeping channel drives");

    property p_pinDefaults;
        @(posedge clk) disable iff (!rstn)
            !regMode |=> regBank[`REG_TUNE_ADJ] == `TUNE_ADJ_DEFAULT && !sdoOe;
    endproperty
    a_pinDefaults: assert property (p_pinDefaults) else $error("defaults not held");

    property p_phaseReg;
        @(posedge clk) disable iff (!rstn)
            regMode && mainReg[`BIT_PHASE] ##1 regMode |-> outputPhase90;
    endproperty
    a_phaseReg: assert property (p_phaseReg) else $error("phase bit ignored");

    property p_phasePin;
        @(posedge clk) disable iff (!rstn) !regMode && !phaseS |=> !outputPhase90;
    endproperty
    a_phasePin: assert property (p_phasePin) else $error("phase pin ignored");

    property p_busPin;
        @(posedge clk) disable iff (!rstn) ##1 singleBusMode == $past(busS);
    endproperty
    a_busPin: assert property (p_busPin) else $error("bus count wrong");

    property p_runHold;
        @(posedge clk) disable iff (!rstn) tuneRunning |-> dataForceLow;
    endproperty
    a_runHold: assert property (p_runHold) else $error("data not held");

    property p_bitTrigger;
        @(posedge clk) disable iff (!rstn)
            tuneBitRise && !tuneRunning |=> tuneRunning [*8];
    endproperty
    a_bitTrigger: assert property (p_bitTrigger) else $error("tune bit no run");

    property p_firstDummy;
        @(posedge clk) disable iff (!rstn)
            rdReq && isTuneVal(rdAddr) && access && firstPending |=> rdData == `ZERO_WORD;
    endproperty
    a_firstDummy: assert property (p_firstDummy) else $error("first read not dummy");

    property p_fullScale;
        @(posedge clk) disable iff (!rstn) !regMode && fsS |=> fullScaleHighI && fullScaleHighQ;
    endproperty
    a_fullScale: assert property (p_fullScale) else $error("full scale pin ignored");

endmodule : converter_mode_and_tune_control

//--- converter_ctrl_cfg.svh
// Purpose: offsets, bit positions, defaults and counts of the converter control
// Assumes: included by bare name
// Notes: definitions only
`ifndef CONVERTER_CTRL_CFG_SVH
`define CONVERTER_CTRL_CFG_SVH

`define REG_MAIN 4'h0
`define REG_RANGE_I 4'h3
`define REG_TUNE_ADJ 4'h4
`define REG_TUNE_VAL 4'h5
`define REG_RANGE_Q 4'hB
`define BIT_TUNE 15
`define BIT_PHASE 14
`define BIT_SLEEP_I 11
`define BIT_SLEEP_Q 10
`define BIT_ARRAY 7
`define BIT_RANGE 15
`define MAIN_DEFAULT 16'h0000
`define TUNE_ADJ_DEFAULT 16'h4000
`define OTHER_DEFAULT 16'h0000
`define ZERO_WORD 16'h0000
`define TUNE_ARRAY_LEN 8'd183
`define TUNE_LOW_CYC 16'd80
`define TUNE_HIGH_CYC 16'd80
`define TUNE_RUN_CYC 16'd4000
`define CMD_BITS 5'd8
`define FRAME_BITS 5'd24
// idle pin levels: mode high, tune high; select high, sclk low
`define PIN_SYNC_IDLE 7'h48
`define PORT_SYNC_IDLE 3'h4

`endif

//--- converter_ctrl_pkg.sv
// Purpose: shared types of the converter control
// Assumes: nothing
// Notes: constants live in converter_ctrl_cfg.svh
package converter_ctrl_pkg;
    typedef logic [15:0] word_t;
    typedef logic [3:0] regAddr_t;
    typedef logic [7:0] arrayIdx_t;
    typedef enum logic [1:0] {TUNE_SEEK_LOW, TUNE_SEEK_HIGH, TUNE_RUN} tuneState_t;
endpackage : converter_ctrl_pkg

//--- converter_serial_port.sv
// Purpose: 24-bit serial register port, oversampled on clk
// Assumes: sclk far slower than clk; pins synchronised here
// Notes: read data must arrive one clk after rdReq
`timescale 1ns/10ps
`include "converter_ctrl_cfg.svh"
module converter_serial_port (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // gating from mode select
    input wire logic portEnable,
    // serial pins
    input wire logic scsN,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdoOut,
    output logic sdoOe,
    // register side
    output logic rdReq,
    output converter_ctrl_pkg::regAddr_t rdAddr,
    input wire converter_ctrl_pkg::word_t rdData,
    output logic wrStb,
    output converter_ctrl_pkg::regAddr_t wrAddr,
    output converter_ctrl_pkg::word_t wrData
);
    import converter_ctrl_pkg::*;

    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    logic sclkPrev;
    logic [4:0] bitCnt, next_bitCnt;
    logic [22:0] shiftIn, next_shiftIn;
    logic [14:0] shiftOut, next_shiftOut;
    logic readOp, next_readOp;
    logic next_sdoOut, next_sdoOe, next_rdReq, next_wrStb;
    regAddr_t next_rdAddr, next_wrAddr;
    word_t next_wrData;
    logic scsS, sclkS, sdiS, rise, fall, active;

    assign {scsS, sclkS, sdiS} = pinSync;
    assign rise = sclkS & ~sclkPrev;
    assign fall = ~sclkS & sclkPrev;
    assign active = ~scsS & portEnable;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pinMeta <= `PORT_SYNC_IDLE;
            pinSync <= `PORT_SYNC_IDLE;
            sclkPrev <= 1'b0;
        end else begin
            pinMeta <= {scsN, sclk, sdi};
            pinSync <= pinMeta;
            sclkPrev <= sclkS;
        end
    end

    always_comb begin
        next_bitCnt = bitCnt;
        next_shiftIn = shiftIn;
        next_shiftOut = shiftOut;
        next_readOp = readOp;
        next_sdoOut = sdoOut;
        next_sdoOe = sdoOe;
        next_rdReq = 1'b0;
        next_rdAddr = rdAddr;
        next_wrStb = 1'b0;
        next_wrAddr = wrAddr;
        next_wrData = wrData;
        if (!active) begin
            // early release drops the frame
            next_bitCnt = 5'h00;
            next_readOp = 1'b0;
            next_sdoOe = 1'b0;
        end else begin
            if (rise && bitCnt < `FRAME_BITS) begin
                next_shiftIn = {shiftIn[21:0], sdiS};
                next_bitCnt = bitCnt + 5'h01;
                if (bitCnt == `CMD_BITS - 5'h01 && shiftIn[6]) begin
                    next_rdReq = 1'b1;
                    next_rdAddr = shiftIn[3:0];
                    next_readOp = 1'b1;
                end
                if (bitCnt == `FRAME_BITS - 5'h01 && !shiftIn[22]) begin
                    next_wrStb = 1'b1;
                    next_wrAddr = shiftIn[19:16];
                    next_wrData = {shiftIn[14:0], sdiS};
                end
            end
            if (fall && readOp && bitCnt == `CMD_BITS) begin
                next_sdoOe = 1'b1;
                next_sdoOut = rdData[15];
                next_shiftOut = rdData[14:0];
            end else if (fall && readOp && bitCnt > `CMD_BITS && bitCnt < `FRAME_BITS) begin
                next_sdoOut = shiftOut[14];
                next_shiftOut = {shiftOut[13:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bitCnt <= 5'h00;
            shiftIn <= 23'h000000;
            shiftOut <= 15'h0000;
            readOp <= 1'b0;
            sdoOut <= 1'b0;
            sdoOe <= 1'b0;
            rdReq <= 1'b0;
            rdAddr <= 4'h0;
            wrStb <= 1'b0;
            wrAddr <= 4'h0;
            wrData <= 16'h0000;
        end else begin
            bitCnt <= next_bitCnt;
            shiftIn <= next_shiftIn;
            shiftOut <= next_shiftOut;
            readOp <= next_readOp;
            sdoOut <= next_sdoOut;
            sdoOe <= next_sdoOe;
            rdReq <= next_rdReq;
            rdAddr <= next_rdAddr;
            wrStb <= next_wrStb;
            wrAddr <= next_wrAddr;
            wrData <= next_wrData;
        end
    end
endmodule : converter_serial_port

//--- converter_host_model.sv
// Purpose: host controller model driving the serial register port
// Assumes: serial phases of 4 clk each, changes at falling clk edges
// Notes: released sdi toggles so a stale level is never mistaken for data
`timescale 1ns/10ps
`include "converter_ctrl_cfg.svh"
module converter_host_model (
    // clock
    input wire logic clk,
    // serial pins
    output logic scsN,
    output logic sclk,
    output logic sdi,
    input wire logic sdoOut,
    input wire logic sdoOe
);
    import converter_ctrl_pkg::*;
    localparam word_t ACCESS_ON = `TUNE_ADJ_DEFAULT | (16'h0001 << `BIT_ARRAY);
    logic oeSeen;

    initial begin
        scsN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        oeSeen = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // one 24-bit frame; read bits taken late in each high phase
    task automatic frame(input logic rd, input regAddr_t a, input word_t wd, output word_t rdv);
        logic [23:0] bits;
        bits = {rd, 2'b10, a, 1'b0, rd ? 16'h0000 : wd};
        rdv = 16'h0000;
        oeSeen = 1'b0;
        tick(1);
        scsN = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi = bits[i];
            tick(4);
            sclk = 1'b1;
            tick(4);
            if (i < 16) begin
                rdv = {rdv[14:0], sdoOut};
            end
            oeSeen = oeSeen | sdoOe;
            sclk = 1'b0;
        end
        tick(4);
        scsN = 1'b1;
        sdi = ~sdi;
        tick(4);
    endtask : frame

    task automatic saveArray(output word_t vals[183]);
        word_t v;
        frame(1'b0, `REG_TUNE_ADJ, ACCESS_ON, v);
        frame(1'b1, `REG_TUNE_VAL, 16'h0000, v); // dummy first read
        for (int k = 0; k < `TUNE_ARRAY_LEN; k++) begin
            frame(1'b1, `REG_TUNE_VAL, 16'h0000, vals[k]);
        end
        frame(1'b0, `REG_TUNE_ADJ, `TUNE_ADJ_DEFAULT, v);
    endtask : saveArray

    task automatic restoreArray(input word_t vals[183]);
        word_t v;
        frame(1'b0, `REG_TUNE_ADJ, ACCESS_ON, v);
        for (int k = 0; k < `TUNE_ARRAY_LEN; k++) begin
            frame(1'b0, `REG_TUNE_VAL, vals[k], v);
        end
        frame(1'b0, `REG_TUNE_VAL, `ZERO_WORD, v);
        frame(1'b0, `REG_TUNE_VAL, `ZERO_WORD, v);
        frame(1'b0, `REG_TUNE_ADJ, `TUNE_ADJ_DEFAULT, v);
    endtask : restoreArray
endmodule : converter_host_model

//--- converter_mode_and_tune_control_bench.sv
// Purpose: self-checking bench of the converter mode and tune control
// Assumes: host model owns the serial pins, bench owns the control pins
// Notes: tune array save and restore take most of the run
`timescale 1ns/10ps
`include "converter_ctrl_cfg.svh"
module converter_mode_and_tune_control_bench;
    import converter_ctrl_pkg::*;
    logic clk, rstn, modeSelectPin, singleBusSelect, outputPhasePin, tunePin;
    logic iChannelSleepPin, qChannelSleepPin, fullScaleSelect, scsN, sclk, sdi;
    logic sdoOut, sdoOe, registerControlMode, singleBusMode, outputPhase90;
    logic iSleep, qSleep, iDataOe, qDataOe, fullScaleHighI, fullScaleHighQ;
    logic tuneRunning, dataForceLow;
    word_t runCnt, dflMiss;
    int failCount = 0;
    int nChecks = 0;

    converter_mode_and_tune_control DUT (
        .clk(clk), .rstn(rstn), .modeSelectPin(modeSelectPin),
        .singleBusSelect(singleBusSelect), .outputPhasePin(outputPhasePin),
        .tunePin(tunePin), .iChannelSleepPin(iChannelSleepPin),
        .qChannelSleepPin(qChannelSleepPin), .fullScaleSelect(fullScaleSelect),
        .scsN(scsN), .sclk(sclk), .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .registerControlMode(registerControlMode), .singleBusMode(singleBusMode),
        .outputPhase90(outputPhase90), .iSleep(iSleep), .qSleep(qSleep),
        .iDataOe(iDataOe), .qDataOe(qDataOe), .fullScaleHighI(fullScaleHighI),
        .fullScaleHighQ(fullScaleHighQ), .tuneRunning(tuneRunning),
        .dataForceLow(dataForceLow)
    );

    converter_host_model host (
        .clk(clk), .scsN(scsN), .sclk(sclk), .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // run length and force-low agreement, seen before each edge's update
    always @(posedge clk) begin
        if (tuneRunning === 1'b1) begin
            runCnt <= runCnt + 16'h0001;
        end
        if (dataForceLow !== tuneRunning) begin
            dflMiss <= dflMiss + 16'h0001;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic report(input word_t got, input word_t exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : report

    task automatic chkBit(input logic got, input logic exp);
        report({15'h0000, got}, {15'h0000, exp});
    endtask : chkBit

    task automatic chkWord(input word_t got, input word_t exp);
        report(got, exp);
    endtask : chkWord

    task automatic wr(input regAddr_t a, input word_t d);
        word_t v;
        host.frame(1'b0, a, d, v);
    endtask : wr

    task automatic rd(input regAddr_t a, output word_t v);
        host.frame(1'b1, a, 16'h0000, v);
    endtask : rd

    task automatic pinModeCase;
        logic b;
        word_t v;
        for (int k = 0; k < 2; k++) begin
            b = k[0];
            iChannelSleepPin = b;
            qChannelSleepPin = !b;
            outputPhasePin = b;
            fullScaleSelect = !b;
            singleBusSelect = b;
            tick(6);
            chkBit(iSleep, b);
            chkBit(iDataOe, !b);
            chkBit(qDataOe, b);
            chkBit(outputPhase90, b);
            chkBit(fullScaleHighI, !b);
            chkBit(fullScaleHighQ, !b);
            chkBit(singleBusMode, b);
            chkBit(registerControlMode, 1'b0);
        end
        rd(`REG_MAIN, v);
        chkBit(host.oeSeen, 1'b0);
    endtask : pinModeCase

    task automatic regModeCase;
        word_t v;
        modeSelectPin = 1'b0;
        singleBusSelect = 1'b0;
        outputPhasePin = 1'b1;
        fullScaleSelect = 1'b1;
        iChannelSleepPin = 1'b0;
        qChannelSleepPin = 1'b0;
        tick(6);
        chkBit(registerControlMode, 1'b1);
        chkBit(outputPhase90, 1'b0);
        outputPhasePin = 1'b0;
        wr(`REG_MAIN, 16'h4800);
        tick(10);
        chkBit(outputPhase90, 1'b1);
        chkBit(iSleep, 1'b1);
        chkBit(iDataOe, 1'b0);
        chkBit(qSleep, 1'b0);
        chkBit(fullScaleHighI, 1'b0);
        qChannelSleepPin = 1'b1;
        singleBusSelect = 1'b1;
        tick(6);
        chkBit(qDataOe, 1'b0);
        chkBit(singleBusMode, 1'b1);
        wr(`REG_RANGE_I, 16'h8000);
        tick(10);
        chkBit(fullScaleHighI, 1'b1);
        chkBit(fullScaleHighQ, 1'b0);
        rd(`REG_MAIN, v);
        chkWord(v, 16'h4800);
        chkBit(host.oeSeen, 1'b1);
        qChannelSleepPin = 1'b0;
        tick(6); // wait out pin sync and output register after wake
        chkBit(qDataOe, 1'b1);
    endtask : regModeCase

    task automatic waitRun;
        for (int i = 0; i < 200 && tuneRunning !== 1'b1; i++) begin
            tick(1);
        end
        for (int i = 0; i < 4200 && tuneRunning !== 1'b0; i++) begin
            tick(1);
        end
    endtask : waitRun

    task automatic tuneCase;
        runCnt = 16'h0000;
        dflMiss = 16'h0000;
        wr(`REG_MAIN, 16'h8000);
        waitRun();
        chkWord(runCnt, `TUNE_RUN_CYC);
        wr(`REG_MAIN, 16'h0000);
        runCnt = 16'h0000;
        tunePin = 1'b0;
        tick(90);
        tunePin = 1'b1;
        waitRun();
        chkWord(runCnt, `TUNE_RUN_CYC);
        chkWord(dflMiss, 16'h0000);
    endtask : tuneCase

    task automatic defaultsCase;
        word_t v;
        wr(`REG_MAIN, 16'h4000);
        wr(`REG_TUNE_ADJ, 16'h0000);
        modeSelectPin = 1'b1;
        tick(10);
        modeSelectPin = 1'b0;
        tick(10);
        rd(`REG_MAIN, v);
        chkWord(v, `MAIN_DEFAULT);
        rd(`REG_TUNE_ADJ, v);
        chkWord(v, `TUNE_ADJ_DEFAULT);
    endtask : defaultsCase

    task automatic arrayCase;
        word_t expv[183];
        word_t got[183];
        word_t v;
        for (int k = 0; k < 183; k++) begin
            expv[k] = word_t'(k) ^ 16'hA55A;
        end
        host.restoreArray(expv);
        host.saveArray(got);
        for (int k = 0; k < 183; k++) begin
            chkWord(got[k], expv[k]);
        end
        rd(`REG_TUNE_VAL, v);
        chkWord(v, `ZERO_WORD);
    endtask : arrayCase

    task automatic wrapUp;
        $display("checks=%0d mismatches=%0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrapUp

    initial begin
        repeat (95000) @(posedge clk);
        failCount++;
        wrapUp();
    end

    initial begin
        rstn = 1'b0;
        modeSelectPin = 1'b1;
        singleBusSelect = 1'b0;
        outputPhasePin = 1'b0;
        tunePin = 1'b1;
        iChannelSleepPin = 1'b0;
        qChannelSleepPin = 1'b0;
        fullScaleSelect = 1'b0;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        tick(4);
        pinModeCase();
        regModeCase();
        tuneCase();
        defaultsCase();
        arrayCase();
        wrapUp();
    end
endmodule : converter_mode_and_tune_control_bench
